// ### shared/cpls_pkg.sv
// Shared constants and types for the control port and list sequencer
package cpls_pkg;
   localparam int NUM_PINS = 7;
   localparam int PIN_W = 3;
   localparam int LIST_DEPTH = 512;
   localparam int LIDX_W = 9;
   localparam int PTS_W = 10;
   localparam int REP_W = 9;
   localparam int CUR_W = 16;
   localparam int MANT_W = 18;
   localparam int UNIT_W = 17;
   localparam int CLK_MHZ = 125;
   // Dwell resolution steps: 1 us, 10 us, 100 us, 1 ms
   localparam int DWELL_UNIT_US = 1;
   localparam int DWELL_CYC_0 = DWELL_UNIT_US * CLK_MHZ;
   localparam int DWELL_CYC_1 = DWELL_CYC_0 * 10;
   localparam int DWELL_CYC_2 = DWELL_CYC_0 * 100;
   localparam int DWELL_CYC_3 = DWELL_CYC_0 * 1000;
   localparam int TOUT_PULSE_US = 1;
   localparam int TOUT_PULSE_CYC = TOUT_PULSE_US * CLK_MHZ;
   localparam logic [PIN_W-1:0] PIN_FAULT = 3'h0;
   localparam logic [PIN_W-1:0] PIN_RETURN = 3'h1;
   localparam logic [PIN_W-1:0] PIN_INHIBIT = 3'h2;
   localparam logic [PTS_W-1:0] POINTS_RST = 10'h001;
   localparam logic [PTS_W-1:0] POINTS_MAX = 10'h200;
   localparam logic [REP_W-1:0] REP_RST = 9'h001;
   localparam logic [REP_W-1:0] REP_MAX = 9'h100;
   localparam logic [CUR_W-1:0] CUR_RST = 16'h0000;
   localparam logic [MANT_W-1:0] DWELL_RST_MANT = 18'h003E8;
   localparam logic [1:0] DWELL_RST_RNG = 2'h0;

   typedef enum logic [2:0] {
      FN_GENERAL_IO = 3'h0,
      FN_INPUT_ONLY = 3'h1,
      FN_TRIGGER_OUT_PIN = 3'h2,
      FN_TRIGGER_IN_PIN = 3'h3,
      FN_FAULT = 3'h4,
      FN_INHIBIT = 3'h5
   } cpls_func_t;

   typedef enum logic [1:0] {
      TM_HOLD_IMMEDIATE_LEVEL = 2'h0,
      TM_STEP = 2'h1,
      TM_LIST = 2'h2
   } cpls_tmode_t;

   typedef enum logic [3:0] {
      SQ_IDLE = 4'h1,
      SQ_ARMED = 4'h2,
      SQ_DWELL = 4'h4,
      SQ_WAIT = 4'h8
   } cpls_seq_t;

   typedef struct packed {
      logic [1:0] rng;
      logic [MANT_W-1:0] mant;
   } cpls_dwell_t;

   typedef struct packed {
      logic [CUR_W-1:0] cur;
      cpls_dwell_t dwell;
   } cpls_step_t;

   typedef struct packed {
      logic ovp;
      logic overcurrent_trip;
      logic ot;
      logic pf;
      logic inh;
   } cpls_prot_t;

   localparam cpls_step_t STEP_RST = '{cur: CUR_RST,
      dwell: '{rng: DWELL_RST_RNG, mant: DWELL_RST_MANT}};
endpackage

// ### verilog/cpls_sync.sv
// Two-flop synchroniser for pin levels
`timescale 1ns/1ps
module cpls_sync #(
   parameter int W = 1
)(
   input wire logic mclk,
   input wire logic reset,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule // cpls_sync

// ### verilog/cpls_dwell_timer.sv
// Dwell timer counting a step's time in scaled microsecond units
`timescale 1ns/1ps
module cpls_dwell_timer
   import cpls_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic start,
   input wire logic stop,
   input wire cpls_dwell_t dwell,
   output logic done
);
   logic [UNIT_W-1:0] unit_cyc;
   logic [UNIT_W-1:0] pre_r;
   logic [MANT_W-1:0] rem_r;
   logic [1:0] rng_r;
   logic run_r;

   always_comb begin
      unique case (rng_r)
         2'h0: unit_cyc = UNIT_W'(DWELL_CYC_0);
         2'h1: unit_cyc = UNIT_W'(DWELL_CYC_1);
         2'h2: unit_cyc = UNIT_W'(DWELL_CYC_2);
         2'h3: unit_cyc = UNIT_W'(DWELL_CYC_3);
      endcase
   end

   // Prescaler per unit keeps the counter at 18 bits for all ranges
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         run_r <= 1'b0;
         rem_r <= '0;
         pre_r <= '0;
         rng_r <= 2'h0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (stop) begin
            run_r <= 1'b0;
         end else if (start) begin
            run_r <= 1'b1;
            rem_r <= dwell.mant;
            rng_r <= dwell.rng;
            pre_r <= '0;
         end else if (run_r) begin
            if (rem_r == '0) begin
               done <= 1'b1;
               run_r <= 1'b0;
            end else if (pre_r == unit_cyc - 17'h00001) begin
               pre_r <= '0;
               rem_r <= rem_r - 18'h00001;
            end else begin
               pre_r <= pre_r + 17'h00001;
            end
         end
      end
   end
endmodule // cpls_dwell_timer

// ### verilog/cpls_top.sv
// Control port pin logic and one channel's list sequencer
`timescale 1ns/1ps
// How it works
// - Input read returns live pins, bits 0-6
// - General pins drive matching written bit
// - Output read-back returns last written value
// - Per-pin function select, restored after reset
// - Input-only pins ignore data, stay undriven
// - Trigger out pulses only when enabled
// - Trigger-in pins feed measure and transient
// - Fault pin true on any protection
// - Pin 2 locked, reports fault
// - Leaving fault makes pin 2 input-only
// - Inhibit pin true disables all channels
// - Per-pin polarity, restored after reset
// - Trigger polarity selects rising/falling edge
// - Repeat count 1..256 or endless
// - Endless list runs until abort
// - List holds 512 steps, resets one
// - Points query returns step count
// - Dwell range with four resolutions
// - Dwell list runs in order, default 1ms
// - Hold_immediate_level, step, list transient modes
// - Overcurrent trip latches until cleared
// - Once mode advances per trigger only
module cpls_top
   import cpls_pkg::*;
#(
   parameter int NUM_CH = 4,
   parameter int TOUT_CYC = TOUT_PULSE_CYC
)(
   input wire logic mclk,
   input wire logic reset,
   input wire logic [NUM_PINS-1:0] pin_in,
   output logic [NUM_PINS-1:0] pin_out,
   output logic [NUM_PINS-1:0] pin_oe_n,
   input wire cpls_func_t [NUM_PINS-1:0] nv_func,
   input wire logic [NUM_PINS-1:0] nv_pol,
   input wire logic func_wr,
   input wire logic [PIN_W-1:0] func_pin,
   input wire cpls_func_t func_val,
   input wire logic pol_wr,
   input wire logic [PIN_W-1:0] pol_pin,
   input wire logic pol_val,
   output cpls_func_t [NUM_PINS-1:0] func_q,
   output logic [NUM_PINS-1:0] pol_q,
   input wire logic out_data_wr,
   input wire logic [NUM_PINS-1:0] out_data_val,
   output logic [NUM_PINS-1:0] out_data_q,
   output logic [NUM_PINS-1:0] in_data_q,
   input wire logic [NUM_PINS-1:0] meas_trig_mask,
   input wire logic [NUM_PINS-1:0] tran_trig_mask,
   input wire logic tran_trig_sw,
   output logic meas_trig,
   input wire logic list_wr,
   input wire logic [LIDX_W-1:0] list_addr,
   input wire cpls_step_t list_step,
   input wire logic list_points_wr,
   input wire logic [PTS_W-1:0] list_points,
   output logic [PTS_W-1:0] points_q,
   input wire logic [REP_W-1:0] rep_count,
   input wire logic endless_repeat,
   input wire logic step_once,
   input wire cpls_tmode_t tran_mode,
   input wire logic step_tout_en,
   input wire logic list_tout_en,
   input wire logic initiate,
   input wire logic abort,
   input wire logic [CUR_W-1:0] imm_level,
   input wire logic [CUR_W-1:0] trig_level,
   output logic [CUR_W-1:0] level_out,
   output logic list_busy,
   output logic [LIDX_W-1:0] step_idx_q,
   input wire logic output_on,
   input wire logic ocp_enable,
   input wire logic cc_mode,
   input wire logic ovp_trip,
   input wire logic ot_trip,
   input wire logic pf_trip,
   input wire logic prot_clear,
   input wire logic [NUM_CH-2:0] other_prot,
   output cpls_prot_t prot_q,
   output logic chan_enable,
   output logic inhibit_all
);
   function automatic logic pol_apply(input logic v, input logic lo);
      return v ^ lo;
   endfunction

   default clocking asrt_cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   cpls_func_t [NUM_PINS-1:0] func_r;
   logic [NUM_PINS-1:0] pol_r;
   logic nv_done_r;
   logic [NUM_PINS-1:0] pin_s;
   logic [NUM_PINS-1:0] pin_lg;
   logic [NUM_PINS-1:0] lg_prev_r;
   logic [1:0] settle_r;
   logic [NUM_PINS-1:0] trig_edge;
   logic [NUM_PINS-1:0] drive_v;
   logic [NUM_PINS-1:0] drive_en;
   logic pin2_locked;
   logic func_legal;
   logic tran_trig;
   logic inhibit_now;
   logic ocp_r;
   logic fault_now;
   logic [$clog2(TOUT_CYC+1)-1:0] tout_cnt_r;
   logic tout_req_r;
   cpls_step_t mem_r [LIST_DEPTH];
   cpls_seq_t seq_r;
   logic [LIDX_W-1:0] idx_nxt;
   logic [REP_W-1:0] pass_r;
   logic [REP_W-1:0] pass_inc;
   logic [REP_W-1:0] rep_r;
   logic endless_r;
   logic last_step;
   logic done_all;
   logic adv;
   logic held_r;
   logic dwell_start_r;
   cpls_dwell_t dwell_r;
   logic dwell_done;

   assign pin2_locked = func_r[PIN_FAULT] == FN_FAULT;

   // Pin levels come from another domain, so they pass two flops first
   cpls_sync #(.W(NUM_PINS)) u_pin_sync (
      .mclk(mclk),
      .reset(reset),
      .d(pin_in),
      .q(pin_s)
   );

   always_comb begin
      func_legal = func_pin < PIN_W'(NUM_PINS) && func_val <= FN_INHIBIT;
      if (func_val == FN_FAULT && func_pin != PIN_FAULT)
         func_legal = 1'b0;
      if (func_val == FN_INHIBIT && func_pin != PIN_INHIBIT)
         func_legal = 1'b0;
      if (pin2_locked && func_pin == PIN_RETURN)
         func_legal = 1'b0;
   end

   // Saved pin settings are taken on the first edge after reset release
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < NUM_PINS; i++)
            func_r[i] <= FN_GENERAL_IO;
         pol_r <= '0;
         nv_done_r <= 1'b0;
      end else if (!nv_done_r) begin
         func_r <= nv_func;
         pol_r <= nv_pol;
         nv_done_r <= 1'b1;
      end else begin
         if (func_wr && func_legal)
            func_r[func_pin] <= func_val;
         if (func_wr && func_legal && func_pin == PIN_FAULT && pin2_locked &&
             func_val != FN_FAULT)
            func_r[PIN_RETURN] <= FN_INPUT_ONLY;
         if (pol_wr && pol_pin < PIN_W'(NUM_PINS) &&
             !(pin2_locked && pol_pin == PIN_RETURN))
            pol_r[pol_pin] <= pol_val;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < NUM_PINS; i++)
            func_q[i] <= FN_GENERAL_IO;
         pol_q <= '0;
         out_data_q <= '0;
         in_data_q <= '0;
      end else begin
         func_q <= func_r;
         if (pin2_locked)
            func_q[PIN_RETURN] <= FN_FAULT;
         pol_q <= pol_r;
         if (out_data_wr)
            out_data_q <= out_data_val;
         in_data_q <= pin_s;
      end
   end

   // Pin drive and edge detection, one slice per pin
   for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      assign pin_lg[i] = pol_apply(pin_s[i], pol_r[i]);
      assign trig_edge[i] = func_r[i] == FN_TRIGGER_IN_PIN &&
         settle_r == 2'h3 && pin_lg[i] && !lg_prev_r[i];
      always_comb begin
         drive_v[i] = 1'b0;
         drive_en[i] = 1'b0;
         unique case (func_r[i])
            FN_GENERAL_IO: begin
               drive_v[i] = out_data_q[i];
               drive_en[i] = 1'b1;
            end
            FN_TRIGGER_OUT_PIN: begin
               drive_v[i] = tout_cnt_r != '0;
               drive_en[i] = 1'b1;
            end
            FN_FAULT: begin
               drive_v[i] = fault_now;
               drive_en[i] = 1'b1;
            end
            FN_INPUT_ONLY, FN_TRIGGER_IN_PIN, FN_INHIBIT: begin
               drive_en[i] = 1'b0;
            end
            default: begin
               drive_en[i] = 1'b0;
            end
         endcase
         if (i == int'(PIN_RETURN) && pin2_locked)
            drive_en[i] = 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         pin_out <= '0;
         pin_oe_n <= '1;
         lg_prev_r <= '0;
         settle_r <= 2'h0;
         meas_trig <= 1'b0;
      end else begin
         pin_out <= drive_v ^ pol_r;
         pin_oe_n <= ~drive_en;
         lg_prev_r <= pin_lg;
         // Reset zeros would look like an edge on an active-low pin
         if (settle_r != 2'h3)
            settle_r <= settle_r + 2'h1;
         meas_trig <= |(trig_edge & meas_trig_mask);
      end
   end

   assign tran_trig = tran_trig_sw | |(trig_edge & tran_trig_mask);

   // Protection: overcurrent trip latches, clear only takes once the cause is gone
   assign inhibit_now = func_r[PIN_INHIBIT] == FN_INHIBIT &&
      pin_lg[PIN_INHIBIT];
   assign fault_now = ocp_r | ovp_trip | ot_trip | pf_trip | inhibit_now |
      |other_prot;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ocp_r <= 1'b0;
         prot_q <= '0;
         chan_enable <= 1'b0;
         inhibit_all <= 1'b0;
      end else begin
         if (ocp_enable && cc_mode && chan_enable)
            ocp_r <= 1'b1;
         else if (prot_clear && !cc_mode)
            ocp_r <= 1'b0;
         prot_q <= '{ovp: ovp_trip, overcurrent_trip: ocp_r, ot: ot_trip, pf: pf_trip,
                     inh: inhibit_now};
         chan_enable <= output_on && !ocp_r && !ovp_trip && !ot_trip &&
            !pf_trip && !inhibit_now;
         inhibit_all <= inhibit_now;
      end
   end

   // Trigger-out pulse: its leading edge carries the polarity
   always_ff @(posedge mclk or posedge reset) begin
      if (reset)
         tout_cnt_r <= '0;
      else if (tout_req_r)
         tout_cnt_r <= ($clog2(TOUT_CYC+1))'(TOUT_CYC);
      else if (tout_cnt_r != '0)
         tout_cnt_r <= tout_cnt_r - 1'b1;
   end

   // List storage; edits are refused while a list runs
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < LIST_DEPTH; i++)
            mem_r[i] <= STEP_RST;
         points_q <= POINTS_RST;
      end else if (seq_r == SQ_IDLE) begin
         if (list_wr)
            mem_r[list_addr] <= list_step;
         if (list_points_wr && list_points != '0 && list_points <= POINTS_MAX)
            points_q <= list_points;
      end
   end

   always_comb begin
      last_step = ({1'b0, step_idx_q} + 10'h001) == points_q;
      pass_inc = pass_r + 9'h001;
      done_all = last_step && !endless_r && pass_inc == rep_r;
      adv = (seq_r == SQ_DWELL && dwell_done && (!step_once || done_all)) ||
            (seq_r == SQ_WAIT && tran_trig);
      idx_nxt = last_step ? '0 : step_idx_q + 9'h001;
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         seq_r <= SQ_IDLE;
         step_idx_q <= '0;
         pass_r <= '0;
         rep_r <= REP_RST;
         endless_r <= 1'b0;
         level_out <= CUR_RST;
         held_r <= 1'b0;
         dwell_start_r <= 1'b0;
         dwell_r <= STEP_RST.dwell;
         tout_req_r <= 1'b0;
         list_busy <= 1'b0;
      end else begin
         dwell_start_r <= 1'b0;
         tout_req_r <= 1'b0;
         list_busy <= seq_r == SQ_DWELL || seq_r == SQ_WAIT;
         if (abort) begin
            seq_r <= SQ_IDLE;
            level_out <= imm_level;
            held_r <= 1'b0;
         end else begin
            unique case (seq_r)
               SQ_IDLE: begin
                  if (!held_r)
                     level_out <= imm_level;
                  if (initiate) begin
                     seq_r <= SQ_ARMED;
                     held_r <= 1'b0;
                     endless_r <= endless_repeat;
                     if (rep_count == '0)
                        rep_r <= REP_RST;
                     else if (rep_count > REP_MAX)
                        rep_r <= REP_MAX;
                     else
                        rep_r <= rep_count;
                  end
               end
               SQ_ARMED: begin
                  if (tran_trig) begin
                     seq_r <= SQ_IDLE;
                     unique case (tran_mode)
                        TM_HOLD_IMMEDIATE_LEVEL: begin
                           level_out <= imm_level;
                        end
                        TM_STEP: begin
                           level_out <= trig_level;
                           held_r <= 1'b1;
                           tout_req_r <= step_tout_en;
                        end
                        TM_LIST: begin
                           seq_r <= SQ_DWELL;
                           step_idx_q <= '0;
                           pass_r <= '0;
                           level_out <= mem_r[0].cur;
                           dwell_r <= mem_r[0].dwell;
                           dwell_start_r <= 1'b1;
                           tout_req_r <= list_tout_en;
                        end
                        default: begin
                           seq_r <= SQ_IDLE;
                        end
                     endcase
                  end
               end
               SQ_DWELL, SQ_WAIT: begin
                  if (adv && done_all) begin
                     seq_r <= SQ_IDLE;
                     level_out <= imm_level;
                  end else if (adv) begin
                     seq_r <= SQ_DWELL;
                     step_idx_q <= idx_nxt;
                     if (last_step)
                        pass_r <= pass_inc;
                     level_out <= mem_r[idx_nxt].cur;
                     dwell_r <= mem_r[idx_nxt].dwell;
                     dwell_start_r <= 1'b1;
                     tout_req_r <= list_tout_en;
                  end else if (seq_r == SQ_DWELL && dwell_done) begin
                     seq_r <= SQ_WAIT;
                  end
               end
            endcase
         end
      end
   end

   cpls_dwell_timer u_dwell (
      .mclk(mclk),
      .reset(reset),
      .start(dwell_start_r),
      .stop(abort),
      .dwell(dwell_r),
      .done(dwell_done)
   );

   in_live_a: assert property (1'b1 ##3 1'b1 |->
      in_data_q == $past(pin_in, 3))
      else $error("input read does not follow pins");

   out_readback_a: assert property (out_data_wr |=>
      out_data_q == $past(out_data_val))
      else $error("output read-back lost written value");

   gio_drive_a: assert property (func_r[3] == FN_GENERAL_IO |=>
      !pin_oe_n[3] &&
      pin_out[3] == ($past(out_data_q[3]) ^ $past(pol_r[3])))
      else $error("general pin not driven from its bit");

   in_only_a: assert property (func_r[4] == FN_INPUT_ONLY |=>
      pin_oe_n[4])
      else $error("input-only pin is driven");

   pin2_lock_a: assert property (nv_done_r && pin2_locked &&
      func_wr && func_pin == PIN_RETURN |=>
      $stable(func_r[PIN_RETURN]) ##1 func_q[PIN_RETURN] == FN_FAULT)
      else $error("pin 2 changed while fault mode holds");

   pin2_revert_a: assert property (nv_done_r && pin2_locked ##1
      !pin2_locked |-> $past(!nv_done_r) ||
      func_r[PIN_RETURN] == FN_INPUT_ONLY)
      else $error("pin 2 not input-only after fault mode");

   fault_pin_a: assert property (pin2_locked && fault_now |=>
      !pin_oe_n[0] && pin_out[0] == !$past(pol_r[0]))
      else $error("fault pin not asserted");

   inhibit_a: assert property (inhibit_now |=>
      inhibit_all && !chan_enable)
      else $error("inhibit did not disable outputs");

   // The status copy of the trip lags the latch by one edge
   ocp_trip_a: assert property (ocp_enable && cc_mode &&
      chan_enable |=> ##1 prot_q.overcurrent_trip && !chan_enable)
      else $error("overcurrent did not trip");

   tout_gate_a: assert property (tout_req_r |->
      $past(step_tout_en || list_tout_en))
      else $error("trigger out without enable");

   once_hold_a: assert property (seq_r == SQ_DWELL && step_once &&
      !dwell_done && !abort |=> $stable(step_idx_q))
      else $error("step advanced during dwell");

   points_a: assert property (seq_r == SQ_IDLE && list_points_wr &&
      list_points != '0 && list_points <= POINTS_MAX |=>
      points_q == $past(list_points))
      else $error("points count not taken");
endmodule // cpls_top

// ### dv/cpls_equip.sv
// External equipment wired to the seven control port pins
`timescale 1ns/1ps
module cpls_equip (
   input wire logic [6:0] pin_out,
   input wire logic [6:0] pin_oe_n,
   input wire logic [6:0] ext_val,
   input wire logic [6:0] ext_en,
   output logic [6:0] pin_in
);
   // Released pins not driven via ext_en rise through the pull-up, never keep the old level
   always_comb begin
      for (int i = 0; i < 7; i++) begin
         if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
         else pin_in[i] = ext_en[i] ? ext_val[i] : 1'b1;
      end
   end
endmodule // cpls_equip

// ### dv/cpls_top_test.sv
// Self-checking bench for the control port and list sequencer
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
   $display("wrong value %s exp %0h got %0h", n, e, g); end end
module cpls_top_test;
   import cpls_pkg::*;
   logic mclk, reset, func_wr, pol_wr, pol_val, out_data_wr, tran_trig_sw;
   logic list_wr, list_points_wr, endless_repeat, step_once, step_tout_en;
   logic list_tout_en, initiate, abort, output_on, ocp_enable, cc_mode;
   logic ovp_trip, ot_trip, pf_trip, prot_clear, meas_trig, list_busy;
   logic chan_enable, inhibit_all;
   logic [6:0] pin_out, pin_oe_n, nv_pol, pol_q, out_data_val, ext_val;
   logic [6:0] out_data_q, in_data_q, meas_trig_mask, tran_trig_mask, ext_en;
   wire logic [6:0] pin_in;
   cpls_func_t [6:0] nv_func, func_q;
   cpls_func_t func_val;
   logic [2:0] func_pin, pol_pin, other_prot;
   logic [8:0] list_addr, step_idx_q, rep_count;
   logic [9:0] list_points, points_q;
   logic [15:0] imm_level, trig_level, level_out;
   cpls_step_t list_step;
   cpls_tmode_t tran_mode;
   cpls_prot_t prot_q;
   int fail_count = 0;
   int compares = 0;
   cpls_top #(.NUM_CH(4), .TOUT_CYC(4)) u_dut (.*);
   cpls_equip u_eq (.*);
   initial begin
      mclk = 0;
      forever #4 mclk = ~mclk;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic setf(input int p, input cpls_func_t v);
      cyc(1);
      func_wr = 1;
      func_pin = p[2:0];
      func_val = v;
      cyc(1);
      func_wr = 0;
      cyc(3);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic t_cfg();
      `CHK("func pin5", FN_INPUT_ONLY, func_q[4])
      `CHK("pol", 7'h08, pol_q)
      `CHK("points", POINTS_RST, points_q)
      out_data_wr = 1;
      out_data_val = 7'h05;
      cyc(1);
      out_data_wr = 0;
      cyc(6);
      `CHK("out read", 7'h05, out_data_q)
      // Pin 5 reads pulled up although its data bit is low
      `CHK("pins", 7'h1D, in_data_q)
      $display("done cfg");
   endtask
   task automatic t_fault();
      setf(0, FN_FAULT);
      `CHK("fault idle", 1'b0, pin_in[0])
      ovp_trip = 1;
      cyc(4);
      `CHK("fault own", 1'b1, pin_in[0])
      ovp_trip = 0;
      other_prot = 3'h4;
      cyc(4);
      `CHK("fault other", 1'b1, pin_in[0])
      other_prot = 0;
      setf(1, FN_GENERAL_IO);
      `CHK("pin2 func", FN_FAULT, func_q[1])
      setf(0, FN_GENERAL_IO);
      `CHK("pin2 after", FN_INPUT_ONLY, func_q[1])
      $display("done fault");
   endtask
   task automatic t_inhibit();
      setf(2, FN_INHIBIT);
      ext_en[2] = 1;
      ext_val[2] = 1;
      cyc(5);
      `CHK("inhibit on", 1'b1, inhibit_all)
      `CHK("chan off", 1'b0, chan_enable)
      ext_val[2] = 0;
      cyc(5);
      `CHK("inhibit off", 1'b0, inhibit_all)
      $display("done inhibit");
   endtask
   task automatic t_trig();
      int c;
      c = 0;
      pol_wr = 1;
      pol_pin = 3'h5;
      pol_val = 1;
      cyc(1);
      pol_wr = 0;
      setf(5, FN_TRIGGER_IN_PIN);
      meas_trig_mask = 7'h20;
      ext_en[5] = 1;
      ext_val[5] = 1;
      cyc(8);
      ext_val[5] = 0;
      repeat (10) begin
         cyc(1);
         c += (meas_trig === 1'b1);
      end
      ext_val[5] = 1;
      repeat (10) begin
         cyc(1);
         c += 2 * (meas_trig === 1'b1);
      end
      // Active low: only the falling pin edge may trigger
      `CHK("trig edges", 1, c)
      $display("done trig");
   endtask
   task automatic wr_step(input int a, input logic [15:0] c);
      list_wr = 1;
      list_addr = a[8:0];
      list_step = '{cur: c, dwell: '{rng: 2'h0, mant: 18'h00002}};
      cyc(1);
      list_wr = 0;
      cyc(1);
   endtask
   task automatic t_list();
      int n, hits, t0, dw;
      logic [15:0] prev;
      {hits, t0, dw, prev} = '0;
      wr_step(0, 16'h0011);
      wr_step(1, 16'h0022);
      list_points_wr = 1;
      list_points = 10'h002;
      rep_count = 9'h002;
      tran_mode = TM_LIST;
      imm_level = 16'h0005;
      cyc(1);
      list_points_wr = 0;
      initiate = 1;
      cyc(1);
      initiate = 0;
      cyc(1);
      tran_trig_sw = 1;
      cyc(1);
      tran_trig_sw = 0;
      for (n = 0; n < 2000; n++) begin
         cyc(1);
         if (level_out === 16'h0011 && prev !== 16'h0011) hits++;
         if (hits == 1 && prev !== 16'h0011 && level_out === 16'h0011) t0 = n;
         if (dw == 0 && level_out === 16'h0022) dw = n - t0;
         prev = level_out;
         if (n > 3 && list_busy === 1'b0) break;
      end
      if (n == 2000) begin
         fail_count++;
         print_verdict();
      end
      // Two units of 125 cycles plus the timer's start-up
      `CHK("dwell ok", 1, int'(dw >= 250 && dw <= 253))
      `CHK("passes", 2, hits)
      `CHK("end level", 16'h0005, level_out)
      `CHK("points", 10'h002, points_q)
      $display("done list");
   endtask
   task automatic fire(output int c);
      initiate = 1;
      cyc(1);
      initiate = 0;
      cyc(1);
      tran_trig_sw = 1;
      cyc(1);
      tran_trig_sw = 0;
      c = 0;
      repeat (10) begin
         cyc(1);
         c += (pin_in[6] === 1'b1);
      end
   endtask
   task automatic t_step();
      int c;
      setf(6, FN_TRIGGER_OUT_PIN);
      tran_mode = TM_STEP;
      trig_level = 16'h0033;
      step_tout_en = 1;
      fire(c);
      `CHK("step tout", 4, c)
      `CHK("step level", 16'h0033, level_out)
      tran_mode = TM_HOLD_IMMEDIATE_LEVEL;
      step_tout_en = 0;
      fire(c);
      `CHK("no tout", 0, c)
      `CHK("hold level", 16'h0005, level_out)
      tran_mode = TM_LIST;
      {step_once, endless_repeat, list_tout_en} = 3'h7;
      rep_count = 9'h001;
      fire(c);
      `CHK("list tout", 4, c)
      cyc(400);
      `CHK("once wait", 9'h000, step_idx_q)
      tran_trig_sw = 1;
      cyc(1);
      tran_trig_sw = 0;
      cyc(2);
      `CHK("once step", 9'h001, step_idx_q)
      cyc(1200);
      `CHK("endless", 1'b1, list_busy)
      abort = 1;
      cyc(1);
      abort = 0;
      cyc(2);
      `CHK("abort", 1'b0, list_busy)
      `CHK("abort level", 16'h0005, level_out)
      $display("done step");
   endtask
   task automatic t_ocp();
      ocp_enable = 1;
      cc_mode = 1;
      cyc(3);
      `CHK("ocp bit", 1'b1, prot_q.overcurrent_trip)
      `CHK("ocp off", 1'b0, chan_enable)
      prot_clear = 1;
      cyc(1);
      prot_clear = 0;
      cyc(2);
      `CHK("ocp held", 1'b1, prot_q.overcurrent_trip)
      cc_mode = 0;
      prot_clear = 1;
      cyc(1);
      prot_clear = 0;
      cyc(3);
      `CHK("ocp clear", 1'b0, prot_q.overcurrent_trip)
      `CHK("chan back", 1'b1, chan_enable)
      $display("done ocp");
   endtask
   initial begin
      {func_wr, pol_wr, pol_val, out_data_wr, tran_trig_sw, list_wr} = '0;
      {list_points_wr, endless_repeat, step_once, step_tout_en} = '0;
      {list_tout_en, initiate, abort, ocp_enable, cc_mode, ovp_trip} = '0;
      {ot_trip, pf_trip, prot_clear, other_prot, ext_val, ext_en} = '0;
      {func_pin, pol_pin, out_data_val, meas_trig_mask, tran_trig_mask} = '0;
      {list_addr, rep_count, list_points, imm_level, trig_level} = '0;
      list_step = STEP_RST;
      tran_mode = TM_HOLD_IMMEDIATE_LEVEL;
      func_val = FN_GENERAL_IO;
      for (int i = 0; i < 7; i++) nv_func[i] = FN_GENERAL_IO;
      nv_func[4] = FN_INPUT_ONLY;
      nv_pol = 7'h08;
      output_on = 1;
      reset = 1;
      cyc(6);
      reset = 0;
      cyc(4);
      t_cfg();
      t_fault();
      t_inhibit();
      t_trig();
      t_list();
      t_step();
      t_ocp();
      print_verdict();
   end
endmodule // cpls_top_test
